/* File: core/ext_bus_controller.sv */
/*
  controller end of the link: samples the mode pin after its reset,
  runs external bus cycles ordered over axi4-lite, stretches strobes
  while the stall pin is high unless stall-disable is set.
  assumes a single-word axi4-lite master and the generator on the link.
*/
module ext_bus_controller (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // axi4-lite slave
  input  wire logic [mm_wait_pkg::ADDR_W-1:0] s_awaddr,
  input  wire logic                       s_awvalid,
  output logic                            s_awready,
  input  wire logic [31:0]                s_wdata,
  input  wire logic [3:0]                 s_wstrb,
  input  wire logic                       s_wvalid,
  output logic                            s_wready,
  output logic [1:0]                      s_bresp,
  output logic                            s_bvalid,
  input  wire logic                       s_bready,
  input  wire logic [mm_wait_pkg::ADDR_W-1:0] s_araddr,
  input  wire logic                       s_arvalid,
  output logic                            s_arready,
  output logic [31:0]                     s_rdata,
  output logic [1:0]                      s_rresp,
  output logic                            s_rvalid,
  input  wire logic                       s_rready,
  // link
  mm_link_if.ctrl                         link,
  // core side
  output logic                            core_stalled_q
);
  import mm_wait_pkg::*;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    if (a == BUS_CONFIG_ADDR)  is_mapped = 1'b1;
    else if (a == CMD_ADDR)    is_mapped = 1'b1;
    else if (a == STATUS_ADDR) is_mapped = 1'b1;
    else                       is_mapped = 1'b0;
  endfunction : is_mapped

  // ==========================================================
  // registers and axi write path
  logic [7:0]            bus_config_q;
  logic [1:0]            kind_q;
  logic [2:0]            beats_q;
  logic [ADDR_LINES-1:0] addr_q;
  logic                  cmd_pend_q;
  logic                  busy_q;
  logic                  boot_ext_q;
  logic                  boot_done_q;
  logic [7:0]            stall_cnt_q;
  logic [ADDR_W-1:0]     awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  aw_got_q;
  logic                  w_got_q;
  logic                  do_write;
  bus_state_e            state_q;

  assign s_awready = ~aw_got_q & ~s_bvalid & rst_n;
  assign s_wready  = ~w_got_q & ~s_bvalid & rst_n;
  assign do_write  = aw_got_q & w_got_q & ~s_bvalid;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      s_bvalid <= 1'b0;
      s_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end
      if (do_write)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      bus_config_q <= BUS_CONFIG_RST;
    else if (do_write && awaddr_q == BUS_CONFIG_ADDR && wstrb_q[0])
      bus_config_q <= wdata_q[7:0];
  end

  // a command written while a cycle runs is dropped, not queued
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cmd_pend_q <= 1'b0;
      kind_q     <= '0;
      beats_q    <= '0;
    end
    else if (do_write && awaddr_q == CMD_ADDR && !busy_q && wstrb_q[1:0] == 2'b11)
    begin
      cmd_pend_q <= 1'b1;
      kind_q     <= wdata_q[CMD_KIND_LSB +: 2];
      beats_q    <= wdata_q[CMD_BEATS_LSB +: 3];
    end
    else if (state_q == ST_IDLE && cmd_pend_q && boot_done_q)
      cmd_pend_q <= 1'b0;
  end

  // ==========================================================
  // axi read path
  assign s_arready = ~s_rvalid & rst_n;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_rvalid <= 1'b0;
      s_rdata  <= '0;
      s_rresp  <= RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_rvalid <= 1'b1;
      s_rresp  <= is_mapped(s_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_araddr == BUS_CONFIG_ADDR)
        s_rdata <= {24'h000000, bus_config_q};
      else if (s_araddr == STATUS_ADDR)
        s_rdata <= {16'h0000, stall_cnt_q, 5'h00, boot_done_q, boot_ext_q, busy_q | cmd_pend_q};
      else
        s_rdata <= 32'h00000000;
    end
    else if (s_rvalid && s_rready)
      s_rvalid <= 1'b0;
  end

  // ==========================================================
  // boot mode sampling, on the controller reset from the link
  logic [1:0] hold_cnt_q;

  always_ff @(posedge core_clk)
  begin
    if (!link.controller_reset_input_n)
    begin
      hold_cnt_q  <= '0;
      boot_done_q <= 1'b0;
      boot_ext_q  <= 1'b0;
    end
    else if (!boot_done_q && hold_cnt_q == 2'(HOLD_CLOCKS - 1))
    begin
      boot_done_q <= 1'b1;
      boot_ext_q  <= ~link.mode_or_stall_pin;
    end
    else if (!boot_done_q)
      hold_cnt_q <= hold_cnt_q + 2'h1;
  end

  // ==========================================================
  // external bus cycle
  logic [1:0] phase_q;
  logic       stall_req;
  logic       is_read;

  assign stall_req = link.mode_or_stall_pin & ~bus_config_q[STALL_DISABLE_BIT];
  assign is_read   = (kind_q == KIND_CODE_READ) || (kind_q == KIND_DATA_READ);

  always_ff @(posedge core_clk)
  begin
    if (!link.controller_reset_input_n)
    begin
      state_q                       <= ST_IDLE;
      busy_q                        <= 1'b0;
      phase_q                       <= '0;
      addr_q                        <= '0;
      stall_cnt_q                   <= '0;
      core_stalled_q                <= 1'b0;
      link.address_latch_strobe     <= 1'b1;
      link.code_read_strobe_n       <= 1'b1;
      link.data_read_strobe_n       <= 1'b1;
      link.low_byte_write_strobe_n  <= 1'b1;
      link.high_byte_write_strobe_n <= 1'b1;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          link.address_latch_strobe <= 1'b0;
          if (cmd_pend_q && boot_done_q)
          begin
            link.address_latch_strobe <= 1'b1;
            busy_q                    <= 1'b1;
            addr_q                    <= '0;
            stall_cnt_q               <= '0;
            state_q                   <= ST_ALE;
          end
        end
        ST_ALE:
        begin
          link.address_latch_strobe <= 1'b0;
          state_q                   <= ST_HOLD;
        end
        ST_HOLD:
        begin
          link.code_read_strobe_n       <= ~(kind_q == KIND_CODE_READ);
          link.data_read_strobe_n       <= ~(kind_q == KIND_DATA_READ);
          link.low_byte_write_strobe_n  <= ~(kind_q == KIND_WRITE_LOW);
          link.high_byte_write_strobe_n <= ~(kind_q == KIND_WRITE_HIGH);
          phase_q                       <= '0;
          state_q                       <= ST_STROBE;
        end
        ST_STROBE:
        begin
          if (phase_q != 2'(STROBE_MIN_CYC - 1))
            phase_q <= phase_q + 2'h1;
          else if (stall_req)
          begin
            core_stalled_q <= 1'b1;
            stall_cnt_q    <= stall_cnt_q + 8'h01;
          end
          else if (is_read && beats_q != 3'h0 && addr_q != ADDR_LINES'(beats_q))
          begin
            core_stalled_q <= 1'b0;
            addr_q         <= addr_q + ADDR_LINES'(1);
            phase_q        <= '0;
          end
          else
          begin
            core_stalled_q                <= 1'b0;
            link.code_read_strobe_n       <= 1'b1;
            link.data_read_strobe_n       <= 1'b1;
            link.low_byte_write_strobe_n  <= 1'b1;
            link.high_byte_write_strobe_n <= 1'b1;
            state_q                       <= ST_END;
          end
        end
        ST_END:
        begin
          busy_q  <= 1'b0;
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  assign link.addr_low = addr_q;

endmodule : ext_bus_controller

/* File: core/mm_link_if.sv */
/*
  link between the bus controller end and the wait/mode generator end.
  assumes both ends share core_clk; the bench resolves nothing, every
  signal has one driver.
*/
interface mm_link_if;
  import mm_wait_pkg::*;

  logic                  address_latch_strobe;
  logic                  code_read_strobe_n;
  logic                  data_read_strobe_n;
  logic                  low_byte_write_strobe_n;
  logic                  high_byte_write_strobe_n;
  logic [ADDR_LINES-1:0] addr_low;
  logic                  controller_reset_input_n;
  logic                  mode_or_stall_pin;

  modport ctrl (
    output address_latch_strobe, code_read_strobe_n, data_read_strobe_n,
    output low_byte_write_strobe_n, high_byte_write_strobe_n, addr_low,
    input  controller_reset_input_n, mode_or_stall_pin
  );

  modport gen (
    input  address_latch_strobe, code_read_strobe_n, data_read_strobe_n,
    input  low_byte_write_strobe_n, high_byte_write_strobe_n, addr_low,
    output controller_reset_input_n, mode_or_stall_pin
  );

endinterface : mm_link_if

/* File: core/mm_wait_pkg.sv */
/*
  shared constants for the memory-mode / stall pin link: register map,
  field positions, reset values, timing counts and state encodings.
  assumes a single 50 mhz core_clk on both ends of the link.
*/
package mm_wait_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int HOLD_CLOCKS     = 3;
  localparam int STROBE_MIN_CYC  = 3;
  localparam int WAIT_SR_W       = 8;
  localparam int WAIT_STATES_DEF = 3;
  localparam int ADDR_LINES      = 3;
  localparam bit MERGE_NOR       = 1'b0;

  // ==========================================================
  // register map, byte addresses on the register bus
  localparam int          ADDR_W          = 16;
  localparam logic [11:0] BUS_CONFIG_IDX  = 12'h46a;
  localparam logic [15:0] BUS_CONFIG_ADDR = {2'b00, BUS_CONFIG_IDX, 2'b00};
  localparam logic [15:0] CMD_ADDR        = 16'h0000;
  localparam logic [15:0] STATUS_ADDR     = 16'h0004;

  // bus_config fields
  localparam int         STALL_DISABLE_BIT = 0;
  localparam logic [7:0] BUS_CONFIG_RST    = 8'h00;

  // command fields
  localparam int CMD_KIND_LSB  = 0;
  localparam int CMD_BEATS_LSB = 4;
  localparam int CMD_ADDR_LSB  = 8;

  // status fields
  localparam int STAT_BUSY      = 0;
  localparam int STAT_BOOT_EXT  = 1;
  localparam int STAT_BOOT_DONE = 2;
  localparam int STAT_STALL_LSB = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    KIND_CODE_READ  = 2'h0,
    KIND_DATA_READ  = 2'h1,
    KIND_WRITE_LOW  = 2'h2,
    KIND_WRITE_HIGH = 2'h3
  } cyc_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ALE    = 3'b001,
    ST_HOLD   = 3'b011,
    ST_STROBE = 3'b010,
    ST_END    = 3'b110
  } bus_state_e;

endpackage : mm_wait_pkg

/* File: core/mode_wait_generator.sv */
/*
  glue logic end of the link: holds the memory-mode level through reset,
  clears it on the first address latch strobe, and stretches selected
  external bus cycles by a counted number of clocks.
  assumes the controller end shares core_clk, that rst_n is the clean
  system reset, and that peripheral_select_low is already decoded.
*/
import mm_wait_pkg::*;

// Functional notes
// - mode flop set while system reset low
// - first latch strobe rising edge clears mode
// - mode stays set until that edge
// - external select gives low pin level
// - mode and wait ORed onto pin
// - mode already low before first strobe
// - controller waits only on external strobes
// - controller stalls core during wait
// - stall-disable bit makes controller ignore pin
// - pin is input only at controller
// - wait ends by own count, not strobes
// - burst reads change low address lines
// - non-burst generator only without bursts
// - wait only inside a data strobe
// - trigger qualified by peripheral select
// - controller stretches whole clock periods
// - counter cleared unless selected strobe
// - counter shifts ones while released
// - chosen tap high negates wait
// - strobe negation clears counter
// - optional NOR merge with adjusted polarity
// - controller samples pin three clocks after reset
// - low sample external, high internal boot
module mode_wait_generator #(
  parameter int WAIT_STATES = mm_wait_pkg::WAIT_STATES_DEF
) (
  // clock and reset
  input  wire logic    core_clk,
  input  wire logic    rst_n,
  // link to the bus controller
  mm_link_if.gen       link,
  // peripheral side
  input  wire logic    peripheral_select_low,
  input  wire logic    mode_jumper,
  // observation
  output logic         mode_level_q,
  output logic         wait_active_q,
  output logic         early_strobe_q,
  output logic [15:0]  wait_seq_count_q
);
  import mm_wait_pkg::*;

  // ==========================================================
  // strobe decode

  logic any_strobe;
  logic selected_strobe;

  assign any_strobe = ~(link.code_read_strobe_n
                        & link.data_read_strobe_n
                        & link.low_byte_write_strobe_n
                        & link.high_byte_write_strobe_n);

  assign selected_strobe = any_strobe & ~peripheral_select_low;

  // ==========================================================
  // reset handed to the controller

  logic ctl_reset_n_q;

  // a registered copy keeps the controller reset free of glitches
  always_ff @(posedge core_clk)
  begin
    ctl_reset_n_q <= rst_n;
  end

  assign link.controller_reset_input_n = ctl_reset_n_q;

  // ==========================================================
  // memory-mode level

  logic ale_prev_q;
  logic ale_rise;
  logic mode_q;
  logic mode_d;
  logic mode_out;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ale_prev_q <= 1'b1;
    else
      ale_prev_q <= link.address_latch_strobe;
  end

  // latch strobe sits high through reset, so only a fresh edge counts
  assign ale_rise = link.address_latch_strobe & ~ale_prev_q;

  always_comb
  begin
    mode_d = mode_q;
    if (!rst_n)
      mode_d = 1'b1;
    else if (ale_rise)
      mode_d = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    mode_q <= mode_d;
  end

  assign mode_out = mode_d & ~mode_jumper;

  // ==========================================================
  // wait counter

  logic tap_reached;
  logic wait_d;

  // non-burst: later burst beats get no wait
  stall_shift_counter #(
    .W   (WAIT_SR_W),
    .TAP (WAIT_STATES)
  ) u_counter (
    .clk         (core_clk),
    .rst_n       (rst_n),
    .run         (selected_strobe),
    .tap_reached (tap_reached)
  );

  // count ends wait, strobe alone never holds it
  assign wait_d = selected_strobe & ~tap_reached & rst_n;

  // ==========================================================
  // pin merge

  function automatic logic merge_pin(input logic mode_l, input logic wait_l);
    logic nor_l;
    nor_l = ~(mode_l | wait_l);
    if (MERGE_NOR)
      merge_pin = ~nor_l;
    else
      merge_pin = mode_l | wait_l;
  endfunction : merge_pin

  logic pin_q;

  // mode_d feeds the pin directly so the level falls in the cycle after
  // the latch edge, well before the controller raises its first strobe
  // mode low before strobe
  always_ff @(posedge core_clk)
  begin
    pin_q <= merge_pin(mode_out, wait_d);
  end

  assign link.mode_or_stall_pin = pin_q;

  // ==========================================================
  // observation

  logic wait_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      wait_q <= 1'b0;
    else
      wait_q <= wait_d;
  end

  always_ff @(posedge core_clk)
  begin
    mode_level_q  <= mode_out;
    wait_active_q <= wait_d;
  end

  // sticky: a strobe seen while the mode level still stands means the
  // controller could lock up; only system reset clears it
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      early_strobe_q <= 1'b0;
    else if (any_strobe && mode_q)
      early_strobe_q <= 1'b1;
  end

  // counts each completed wait sequence, wraps silently
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      wait_seq_count_q <= 16'h0000;
    else if (wait_q && !wait_d)
      wait_seq_count_q <= wait_seq_count_q + 16'h0001;
  end

endmodule : mode_wait_generator

/* File: core/stall_shift_counter.sv */
/*
  shift-register wait counter: held clear while run is low, shifts in
  ones while run is high, reports when the chosen tap has filled.
  assumes run is synchronous to clk.
*/
module stall_shift_counter #(
  parameter int W   = 8,
  parameter int TAP = 3
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic run,
  output logic      tap_reached
);

  logic [W-1:0] sr_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
      sr_q <= '0;
    else
      sr_q <= {sr_q[W-2:0], 1'b1};
  end

  assign tap_reached = sr_q[TAP-1];

endmodule : stall_shift_counter

/* File: test/mm_link_asserts.sv */
/*
  concurrent checks on the mode / stall link between the two ends.
  assumes the bench instantiates it beside the link interface.
*/
module mm_link_asserts #(
  parameter int WAIT_STATES = 3
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // link
  input  wire logic address_latch_strobe,
  input  wire logic code_read_strobe_n,
  input  wire logic data_read_strobe_n,
  input  wire logic low_byte_write_strobe_n,
  input  wire logic high_byte_write_strobe_n,
  input  wire logic controller_reset_input_n,
  input  wire logic mode_or_stall_pin,
  // peripheral side
  input  wire logic peripheral_select_low,
  input  wire logic mode_jumper
);
  timeunit 1ns;
  timeprecision 1ps;
  import mm_wait_pkg::*;

  logic       strobing;
  logic       seen_q;
  logic [7:0] run_q;

  assign strobing = !(code_read_strobe_n && data_read_strobe_n && low_byte_write_strobe_n && high_byte_write_strobe_n);

  // seen_q: mode level is known cleared once any strobe has run
  always_ff @(posedge core_clk)
    if (!rst_n) seen_q <= 1'b0;
    else if (strobing) seen_q <= 1'b1;

  // saturates so the long mode-high stretch cannot wrap
  always_ff @(posedge core_clk)
    if (!rst_n || !mode_or_stall_pin) run_q <= 8'h00;
    else if (run_q != 8'hff) run_q <= run_q + 8'h01;

  default clocking cb @(posedge core_clk);
  endclocking

  sequence strobe_start_s;
    $rose(strobing);
  endsequence

  sequence sel_start_s;
    strobe_start_s ##0 !peripheral_select_low;
  endsequence

  mode_preset_a : assert property (!rst_n && !mode_jumper |=> mode_or_stall_pin)
    else $error("mode level not high during reset");
  ext_select_a : assert property (!rst_n && mode_jumper |=> !mode_or_stall_pin)
    else $error("external select not low during reset");
  ctrl_reset_a : assert property (!rst_n |=> !controller_reset_input_n)
    else $error("controller reset not driven low");
  mode_clear_a : assert property (disable iff (!rst_n) strobe_start_s |-> !mode_or_stall_pin)
    else $error("pin high as first strobe starts");
  latch_first_a : assert property (disable iff (!rst_n) strobe_start_s |-> $past(address_latch_strobe, 2))
    else $error("strobe without preceding latch strobe");
  idle_quiet_a : assert property (disable iff (!rst_n) seen_q && !$past(strobing) |-> !mode_or_stall_pin)
    else $error("wait outside a data strobe");
  select_gate_a : assert property (disable iff (!rst_n)
    seen_q && strobing && peripheral_select_low |=> !mode_or_stall_pin)
    else $error("wait for an unselected peripheral");
  wait_rise_a : assert property (disable iff (!rst_n) sel_start_s |=> mode_or_stall_pin)
    else $error("wait not raised at selected strobe");
  wait_len_a : assert property (disable iff (!rst_n)
    seen_q && strobing && $fell(mode_or_stall_pin) |-> run_q == WAIT_STATES)
    else $error("wait length differs from tap");
  wait_bound_a : assert property (disable iff (!rst_n) seen_q |-> run_q <= WAIT_STATES)
    else $error("wait held past its own count");

endmodule : mm_link_asserts

/* File: test/tb_top.sv */
/*
  bench joining both ends of the link, driving the register bus.
  assumes only the designs and the checker beside it.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mm_wait_pkg::*;

  localparam int WS = 4;
  typedef struct packed { logic [1:0] kind; logic sel_n; logic dis; } row_s;
  // disabled rows last: their wait count is left unchecked
  row_s rows [8] = '{'{2'h0, 1'b0, 1'b0}, '{2'h1, 1'b0, 1'b0}, '{2'h2, 1'b0, 1'b0}, '{2'h3, 1'b0, 1'b0},
                     '{2'h1, 1'b1, 1'b0}, '{2'h2, 1'b1, 1'b0}, '{2'h0, 1'b0, 1'b1}, '{2'h3, 1'b0, 1'b1}};

  logic        core_clk, rst_n, sel_low, jumper, mode_level_q, wait_active_q, early_strobe_q, core_stalled_q;
  logic [15:0] s_awaddr, s_araddr, wait_seq_count_q;
  logic [31:0] s_wdata, s_rdata, st, d;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, r;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  int          n_fail, total_checks, exp_waits, s0, w0;
  int          stall_seen = 0;
  int          wait_seen = 0;

  mm_link_if mm_link_if_i ();
  mode_wait_generator #(.WAIT_STATES(WS)) mode_wait_generator_i (.core_clk(core_clk), .rst_n(rst_n),
    .link(mm_link_if_i.gen), .peripheral_select_low(sel_low), .mode_jumper(jumper), .mode_level_q(mode_level_q),
    .wait_active_q(wait_active_q), .early_strobe_q(early_strobe_q), .wait_seq_count_q(wait_seq_count_q));
  ext_bus_controller ext_bus_controller_i (.core_clk(core_clk), .rst_n(rst_n), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .link(mm_link_if_i.ctrl), .core_stalled_q(core_stalled_q));
  mm_link_asserts #(.WAIT_STATES(WS)) mm_link_asserts_i (.core_clk(core_clk), .rst_n(rst_n),
    .address_latch_strobe(mm_link_if_i.address_latch_strobe), .code_read_strobe_n(mm_link_if_i.code_read_strobe_n),
    .data_read_strobe_n(mm_link_if_i.data_read_strobe_n),
    .low_byte_write_strobe_n(mm_link_if_i.low_byte_write_strobe_n),
    .high_byte_write_strobe_n(mm_link_if_i.high_byte_write_strobe_n),
    .mode_or_stall_pin(mm_link_if_i.mode_or_stall_pin),
    .controller_reset_input_n(mm_link_if_i.controller_reset_input_n), .peripheral_select_low(sel_low),
    .mode_jumper(jumper));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // free-running tallies of design flags, read as differences around a command
  always @(posedge core_clk)
  begin
    stall_seen <= stall_seen + int'(core_stalled_q === 1'b1);
    wait_seen  <= wait_seen + int'(wait_active_q === 1'b1);
  end

  // ==========================================================
  // reporting
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // register bus; each wait is bounded and a hang ends the run
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] v, input logic [3:0] sb, output logic [1:0] rs);
    int n;
    @(posedge core_clk);
    n = 0;
    s_awaddr <= a;
    s_wdata <= v;
    s_wstrb <= sb;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (n > 200) begin n_fail++; tally_and_finish(); end
    end while (!s_bvalid);
    rs = s_bresp;
    s_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge core_clk);
    n = 0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (n > 200) begin n_fail++; tally_and_finish(); end
    end while (!s_rvalid);
    v = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
  endtask : axi_rd

  task automatic run_cmd(input logic [31:0] cmd, output logic [31:0] sv);
    logic [1:0] rs;
    int         n;
    axi_wr(CMD_ADDR, cmd, 4'h3, rs);
    n = 0;
    do
    begin
      axi_rd(STATUS_ADDR, sv, rs);
      n++;
      if (n > 50) begin n_fail++; tally_and_finish(); end
    end while (sv[STAT_BUSY] !== 1'b0);
  endtask : run_cmd

  // ==========================================================
  // main sequence
  initial
  begin
    {rst_n, jumper, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    sel_low = 1'b1;
    n_fail = 0;
    total_checks = 0;
    exp_waits = 0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk("mode level idle", 32'h1, {31'h0, mode_level_q});
    axi_rd(BUS_CONFIG_ADDR, d, r);
    chk("bus_config reset", {24'h0, BUS_CONFIG_RST}, d);
    axi_rd(STATUS_ADDR, st, r);
    chk("boot bits", 32'h4, {29'h0, st[2:0]});
    axi_rd(16'h0100, d, r);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {d[29:0], r});
    axi_wr(BUS_CONFIG_ADDR, 32'h1, 4'he, r);
    axi_rd(BUS_CONFIG_ADDR, d, r);
    chk("bus_config strobe", 32'h0, d);
    foreach (rows[i])
    begin
      axi_wr(BUS_CONFIG_ADDR, {31'h0, rows[i].dis}, 4'h1, r);
      sel_low <= rows[i].sel_n;
      s0 = stall_seen;
      w0 = wait_seen;
      run_cmd({30'h0, rows[i].kind}, st);
      chk("stall clocks", (!rows[i].sel_n && !rows[i].dis) ? WS - 1 : 0, {24'h0, st[15:8]});
      chk("core stalled", (!rows[i].sel_n && !rows[i].dis) ? WS - 1 : 0, stall_seen - s0);
      if (!rows[i].dis)
      begin
        exp_waits += !rows[i].sel_n;
        chk("wait count", exp_waits, {16'h0, wait_seq_count_q});
        chk("wait active", !rows[i].sel_n ? WS : 0, wait_seen - w0);
      end
    end
    chk("mode cleared", 32'h0, {31'h0, mode_level_q});
    chk("early strobe", 32'h0, {31'h0, early_strobe_q});
    // burst read: only the first beat of a non-burst generator waits
    axi_wr(BUS_CONFIG_ADDR, 32'h0, 4'h1, r);
    sel_low <= 1'b0;
    run_cmd(32'h31, st);
    chk("burst stall", WS - 1, {24'h0, st[15:8]});
    // second reset with external-only select
    rst_n <= 1'b0;
    jumper <= 1'b1;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("external pin", 32'h0, {31'h0, mm_link_if_i.mode_or_stall_pin});
    axi_rd(STATUS_ADDR, st, r);
    chk("boot external", 32'h6, {29'h0, st[2:0]});
    run_cmd(32'h2, st);
    chk("merged stall", WS - 1, {24'h0, st[15:8]});
    chk("wait count ext", 32'h1, {16'h0, wait_seq_count_q});
    tally_and_finish();
  end

endmodule : tb_top
